//--- verilog/sfd_defines.svh
// constants for the subtract family datapath
`ifndef SFD_DEFINES_SVH
`define SFD_DEFINES_SVH
`define SFD_OPF_BYTE_REG 6'h31
`define SFD_OPF_BYTE_CST 6'h33
`define SFD_OPF_HALF_REG 6'h35
`define SFD_OPF_HALF_CST 6'h37
`define SFD_OPF_WORD_REG 6'h39
`define SFD_OPF_WORD_CST 6'h3B
`define SFD_OPF_ULONG_X2 7'h2F
`define SFD_OPF_ULONG_X1 7'h3F
`define SFD_HALF_SHIFT 1
`define SFD_WORD_SHIFT 2
`define SFD_AMR_BASE_LO 5'h04
`define SFD_AMR_BASE_HI 5'h07
`define SFD_AMR_LINEAR 2'h0
`define SFD_LONG_W 40
`endif

//--- verilog/sfd_pkg.sv
// types for the subtract family datapath
package sfd_pkg;
    typedef enum logic [3:0]
    {
        SFD_OP_ADDR  = 4'h1,
        SFD_OP_ABS4  = 4'h2,
        SFD_OP_CSUB  = 4'h4,
        SFD_OP_ULONG = 4'h8
    } sfd_op_t;
    typedef enum logic [2:0]
    {
        SFD_UNIT_L = 3'h1,
        SFD_UNIT_S = 3'h2,
        SFD_UNIT_D = 3'h4
    } sfd_unit_t;
    typedef struct packed
    {
        logic valid;
        logic pred;
        logic dual_halfword_subtract;
        sfd_op_t op;
        sfd_unit_t unit;
        logic [6:0] opfield;
        logic b_side;
        logic [4:0] src2_reg;
        logic [4:0] dst_reg;
        logic [31:0] src1;
        logic [31:0] src2;
    } sfd_req_t;
    typedef struct packed
    {
        logic we;
        logic pair;
        logic [4:0] dst_reg;
        logic [31:0] lo;
        logic [7:0] hi;
    } sfd_wb_t;
endpackage

//--- verilog/sfd_datapath.sv
// subtract family execute unit, first execute stage
// Contract
// - byte address subtract: src2 minus src1/constant
// - linear default, circular mode for base registers
// - halfword form shifts src1 left one
// - word form shifts src1 left two
// - per byte lane absolute difference
// - bytes unsigned, no borrow between lanes
// - nonnegative difference: write diff shifted plus one
// - negative difference: write src1 shifted left
// - unsigned long subtract into register pair
// - dual halfword subtract on L, S, D
// - low half borrow never reaches high half
`timescale 1ns/10ps
`include "sfd_defines.svh"
module sfd_datapath
    import sfd_pkg::*;
#(
    parameter int BLOCK_W = 5
)
(
    input wire logic clk,
    input wire logic reset,
    input wire sfd_req_t req,
    input wire logic [15:0] amr_mode,
    input wire logic [BLOCK_W-1:0] amr_block0,
    input wire logic [BLOCK_W-1:0] amr_block1,
    output sfd_wb_t wb,
    output logic illegal
);
    // ----------------------------------------
    // address scaled subtract
    // ----------------------------------------
    logic [5:0] opf6;
    logic [31:0] addr_off;
    logic addr_ok;
    logic circ;
    logic [2:0] base_idx;
    logic [1:0] mode_sel;
    logic [BLOCK_W-1:0] blk_exp;
    logic [31:0] blk_mask;
    logic [31:0] lin_res;
    logic [31:0] circ_res;
    logic [31:0] addr_res;
    assign opf6 = req.opfield[5:0];
    always_comb
    begin
        addr_off = 32'h0;
        addr_ok = 1'b1;
        case (opf6)
            `SFD_OPF_BYTE_REG: addr_off = req.src1;
            `SFD_OPF_BYTE_CST: addr_off = {27'h0, req.src1[4:0]};
            `SFD_OPF_HALF_REG: addr_off = req.src1 << `SFD_HALF_SHIFT;
            `SFD_OPF_HALF_CST: addr_off = {27'h0, req.src1[4:0]} << `SFD_HALF_SHIFT;
            `SFD_OPF_WORD_REG: addr_off = req.src1 << `SFD_WORD_SHIFT;
            `SFD_OPF_WORD_CST: addr_off = {27'h0, req.src1[4:0]} << `SFD_WORD_SHIFT;
            default: addr_ok = 1'b0;
        endcase
    end
    // circular only for base registers 4..7 of either side
    assign base_idx = {req.b_side, req.src2_reg[1:0]};
    assign mode_sel = amr_mode[{base_idx, 1'b0} +: 2];
    assign circ = (req.src2_reg >= `SFD_AMR_BASE_LO) && (req.src2_reg <= `SFD_AMR_BASE_HI)
        && (mode_sel != `SFD_AMR_LINEAR);
    assign blk_exp = mode_sel[1] ? amr_block1 : amr_block0;
    // simplified ring: block of 2^(exp+1) bytes, offsets wrap inside it
    assign blk_mask = (32'h2 << blk_exp) - 32'h1;
    assign lin_res = req.src2 - addr_off;
    assign circ_res = (req.src2 & ~blk_mask) | (lin_res & blk_mask);
    assign addr_res = circ ? circ_res : lin_res;
    // ----------------------------------------
    // packed byte absolute difference
    // ----------------------------------------
    logic [31:0] abs_res;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            logic [7:0] a_b;
            logic [7:0] b_b;
            assign a_b = req.src1[8*gi +: 8];
            assign b_b = req.src2[8*gi +: 8];
            // lanes are computed apart, so no borrow crosses them
            assign abs_res[8*gi +: 8] = (a_b >= b_b) ? (a_b - b_b) : (b_b - a_b);
        end
    endgenerate
    // ----------------------------------------
    // conditional subtract, long subtract, dual halfword
    // ----------------------------------------
    logic [32:0] cdiff;
    logic [31:0] csub_res;
    logic [32:0] ldiff;
    logic [31:0] dual_halfword_subtract_res;
    logic ulong_ok;
    assign cdiff = {1'b0, req.src1} - {1'b0, req.src2};
    // unsigned operands: the borrow bit marks a negative difference
    assign csub_res = cdiff[32] ? {req.src1[30:0], 1'b0}
        : {cdiff[30:0], 1'b1};
    assign ldiff = {1'b0, req.src1} - {1'b0, req.src2};
    assign ulong_ok = (req.opfield == `SFD_OPF_ULONG_X2) || (req.opfield == `SFD_OPF_ULONG_X1);
    assign dual_halfword_subtract_res[15:0] = req.src1[15:0] - req.src2[15:0];
    assign dual_halfword_subtract_res[31:16] = req.src1[31:16] - req.src2[31:16];
    // ----------------------------------------
    // result select and writeback register
    // ----------------------------------------
    sfd_wb_t next_wb;
    logic next_illegal;
    always_comb
    begin
        next_wb = '0;
        next_illegal = 1'b0;
        next_wb.dst_reg = req.dst_reg;
        if (req.valid)
        begin
            if (req.dual_halfword_subtract)
            begin
                next_wb.lo = dual_halfword_subtract_res;
                next_wb.we = 1'b1;
            end
            else
            begin
                case (req.op)
                    SFD_OP_ADDR:
                    begin
                        next_wb.lo = addr_res;
                        next_wb.we = addr_ok && (req.unit == SFD_UNIT_D);
                        next_illegal = !next_wb.we;
                    end
                    SFD_OP_ABS4:
                    begin
                        next_wb.lo = abs_res;
                        next_wb.we = (req.unit == SFD_UNIT_L);
                        next_illegal = !next_wb.we;
                    end
                    SFD_OP_CSUB:
                    begin
                        next_wb.lo = csub_res;
                        next_wb.we = (req.unit == SFD_UNIT_L);
                        next_illegal = !next_wb.we;
                    end
                    SFD_OP_ULONG:
                    begin
                        next_wb.lo = ldiff[31:0];
                        // borrow sign-extends through the guard byte
                        next_wb.hi = {8{ldiff[32]}};
                        next_wb.pair = 1'b1;
                        next_wb.we = ulong_ok && (req.unit == SFD_UNIT_L);
                        next_illegal = !next_wb.we;
                    end
                    default: next_illegal = 1'b1;
                endcase
            end
            if (!req.pred)
            begin
                next_wb.we = 1'b0;
                next_illegal = 1'b0;
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wb <= '0;
        end
        else
        begin
            wb <= next_wb;
        end
    end
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            illegal <= 1'b0;
        end
        else
        begin
            illegal <= next_illegal;
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    pred_false_nowrite_a: assert property (req.valid && !req.pred |=> !wb.we)
        else $error("write despite false predicate");
    one_cycle_wb_a: assert property (req.valid && req.pred && req.dual_halfword_subtract |=> wb.we)
        else $error("write not one cycle later");
    byte_sub_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ADDR
        && req.unit == SFD_UNIT_D && opf6 == `SFD_OPF_BYTE_REG && !circ
        |=> wb.lo == $past(req.src2) - $past(req.src1))
        else $error("byte address subtract wrong");
    half_sub_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ADDR
        && req.unit == SFD_UNIT_D && opf6 == `SFD_OPF_HALF_CST && !circ
        |=> wb.lo == $past(req.src2) - {26'h0, $past(req.src1[4:0]), 1'b0})
        else $error("halfword address subtract wrong");
    word_sub_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ADDR
        && req.unit == SFD_UNIT_D && opf6 == `SFD_OPF_WORD_REG && !circ
        |=> wb.lo == $past(req.src2) - {$past(req.src1[29:0]), 2'h0})
        else $error("word address subtract wrong");
    circ_base_only_a: assert property (circ |-> req.src2_reg[4:2] == 3'h1)
        else $error("circular mode on non-base register");
    abs_lane0_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ABS4
        && req.unit == SFD_UNIT_L && req.src1[7:0] == req.src2[7:0] |=> wb.lo[7:0] == 8'h0)
        else $error("absolute difference lane wrong");
    csub_step_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_CSUB
        && req.unit == SFD_UNIT_L && req.src1 < req.src2 |=> wb.lo == {$past(req.src1[30:0]), 1'b0})
        else $error("conditional subtract negative path wrong");
    csub_pos_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_CSUB
        && req.unit == SFD_UNIT_L && req.src1 >= req.src2 |=> wb.lo[0])
        else $error("conditional subtract positive path wrong");
    ulong_hi_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ULONG
        && req.unit == SFD_UNIT_L && ulong_ok |=> wb.pair && wb.hi == {8{$past(req.src1 < req.src2)}})
        else $error("long subtract high part wrong");
    dual_halfword_subtract_halves_a: assert property (req.valid && req.pred && req.dual_halfword_subtract
        |=> wb.lo[31:16] == $past(req.src1[31:16]) - $past(req.src2[31:16]))
        else $error("dual halfword upper half wrong");

    // ----------------------------------------
    // further rule checks
    // ----------------------------------------
    byte_cst_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ADDR && req.unit == SFD_UNIT_D
        && opf6 == `SFD_OPF_BYTE_CST && !circ |=> wb.lo == $past(req.src2) - {27'h0, $past(req.src1[4:0])})
        else $error("byte address constant subtract wrong");

    half_reg_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ADDR && req.unit == SFD_UNIT_D
        && opf6 == `SFD_OPF_HALF_REG && !circ |=> wb.lo == $past(req.src2) - {$past(req.src1[30:0]), 1'b0})
        else $error("halfword address register subtract wrong");

    word_cst_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ADDR && req.unit == SFD_UNIT_D
        && opf6 == `SFD_OPF_WORD_CST && !circ |=> wb.lo == $past(req.src2) - {25'h0, $past(req.src1[4:0]), 2'h0})
        else $error("word address constant subtract wrong");

    circ_keep_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ADDR && req.unit == SFD_UNIT_D
        && addr_ok && circ |=> (wb.lo & ~$past(blk_mask)) == ($past(req.src2) & ~$past(blk_mask)))
        else $error("circular result left its block");

    lin_default_a: assert property (req.src2_reg < `SFD_AMR_BASE_LO || req.src2_reg > `SFD_AMR_BASE_HI
        |-> !circ)
        else $error("circular mode outside base registers");

    abs_lane3_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ABS4 && req.unit == SFD_UNIT_L
        && req.src1[31:24] >= req.src2[31:24] |=> wb.lo[31:24] == $past(req.src1[31:24]) - $past(req.src2[31:24]))
        else $error("absolute difference top lane wrong");

    abs_lane1_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ABS4 && req.unit == SFD_UNIT_L
        && req.src1[15:8] < req.src2[15:8] |=> wb.lo[15:8] == $past(req.src2[15:8]) - $past(req.src1[15:8]))
        else $error("absolute difference lane borrow wrong");

    csub_full_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_CSUB && req.unit == SFD_UNIT_L
        && req.src1 >= req.src2 |=> wb.lo == ((($past(req.src1) - $past(req.src2)) << 1) | 32'h1))
        else $error("conditional subtract positive value wrong");

    ulong_lo_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ULONG && req.unit == SFD_UNIT_L
        && ulong_ok |=> wb.lo == $past(req.src1) - $past(req.src2))
        else $error("long subtract low word wrong");

    ulong_unit_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ULONG && req.unit != SFD_UNIT_L
        |=> illegal && !wb.we)
        else $error("long subtract off its unit");

    addr_unit_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ADDR && req.unit != SFD_UNIT_D
        |=> illegal && !wb.we)
        else $error("address subtract off its unit");

    abs_unit_a: assert property (req.valid && req.pred && !req.dual_halfword_subtract && req.op == SFD_OP_ABS4 && req.unit != SFD_UNIT_L
        |=> illegal && !wb.we)
        else $error("absolute difference off its unit");

    dual_halfword_subtract_low_a: assert property (req.valid && req.pred && req.dual_halfword_subtract
        |=> wb.lo[15:0] == $past(req.src1[15:0]) - $past(req.src2[15:0]))
        else $error("dual halfword lower half wrong");

    dual_halfword_subtract_noborrow_a: assert property (req.valid && req.pred && req.dual_halfword_subtract && req.src1[15:0] < req.src2[15:0]
        && req.src1[31:16] == req.src2[31:16] |=> wb.lo[31:16] == 16'h0)
        else $error("borrow crossed into upper half");

    pred_quiet_a: assert property (req.valid && !req.pred |=> !illegal)
        else $error("refusal flagged despite false predicate");

    idle_quiet_a: assert property (!req.valid |=> !wb.we && !illegal)
        else $error("write without an instruction");

    reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0) reset |=> !wb.we && !illegal)
        else $error("write during reset");

    // ----------------------------------------
    // scenario covers
    // ----------------------------------------
    cov_circ_c: cover property (req.valid && req.pred && circ);
    cov_csub_neg_c: cover property (req.valid && req.pred && req.op == SFD_OP_CSUB && cdiff[32]);
    cov_dual_halfword_subtract_c: cover property (req.valid && req.pred && req.dual_halfword_subtract && req.unit == SFD_UNIT_S);
    cov_pred_off_c: cover property (req.valid && !req.pred);
    cov_ulong_c: cover property (req.valid && req.pred && req.op == SFD_OP_ULONG && ldiff[32]);
endmodule

//--- test/sfd_regfile_model.sv
// register file model that takes the datapath's write-backs
`timescale 1ns/10ps
module sfd_regfile_model
    import sfd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire sfd_wb_t wb,
    output logic [15:0] writes
);
    logic [31:0] regs [32];
    // counts every strobe so the bench can spot stray writes
    always_ff @(posedge clk)
    begin
        if (reset)
            writes <= 16'h0000;
        else if (wb.we)
        begin
            writes <= writes + 16'h0001;
            regs[wb.dst_reg] <= wb.lo;
            if (wb.pair)
                regs[wb.dst_reg + 5'h01] <= {24'h000000, wb.hi};
        end
    end
endmodule

//--- test/subtract_family_datapath_tb.sv
// self-checking bench for the subtract family datapath
`timescale 1ns/10ps
module subtract_family_datapath_tb;
    import sfd_pkg::*;
    logic clk = 0;
    logic reset = 1;
    sfd_req_t req = '0;
    logic [15:0] amr_mode = 16'h0000;
    logic [4:0] amr_block0 = 5'h00;
    logic [4:0] amr_block1 = 5'h00;
    sfd_wb_t wb;
    logic illegal;
    logic [15:0] writes;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int nexp = 0;
    logic [31:0] seed = 32'h61F3;
    always #2.5 clk = ~clk;
    sfd_datapath uut (.clk(clk), .reset(reset), .req(req), .amr_mode(amr_mode), .amr_block0(amr_block0),
        .amr_block1(amr_block1), .wb(wb), .illegal(illegal));
    sfd_regfile_model rf (.clk(clk), .reset(reset), .wb(wb), .writes(writes));
    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(string name, logic [47:0] seen, logic [47:0] want);
        checks++;
        if (seen !== want)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // drives one request, then checks its write-back one cycle later
    task automatic go(sfd_op_t op, sfd_unit_t u, logic [6:0] opf, logic s2, logic pr, logic [31:0] a, logic [31:0] b);
        logic [39:0] d;
        logic [31:0] c;
        logic ill;
        int sh;
        logic [31:0] r;
        logic [31:0] m;
        logic [1:0] md;
        r = rnd();
        md = r[2 * b[1:0] +: 2];
        m = (32'h2 << (md[1] ? r[20:16] : r[25:21])) - 32'h1;
        d = '0;
        ill = (u != SFD_UNIT_L);
        c = opf[1] ? {27'h0, a[4:0]} : a;
        sh = int'(opf[5:0] - 6'h31) >> 2;
        if (s2)
            {ill, d} = {1'b0, 8'h00, a[31:16] - b[31:16], a[15:0] - b[15:0]};
        else if (op == SFD_OP_ADDR)
            {ill, d} = {u != SFD_UNIT_D, 8'h00, b - (c << sh)};
        else if (op == SFD_OP_ABS4)
            for (int i = 0; i < 4; i++)
                d[8*i +: 8] = a[8*i +: 8] > b[8*i +: 8] ? a[8*i +: 8] - b[8*i +: 8] : b[8*i +: 8] - a[8*i +: 8];
        else if (op == SFD_OP_CSUB)
            d[31:0] = a >= b ? ((a - b) << 1) | 32'h1 : a << 1;
        else
            d = {8'h00, a} - {8'h00, b};
        if (op == SFD_OP_ADDR && !s2 && b[4] && md != 2'h0)
            d[31:0] = (b & ~m) | (d[31:0] & m);
        {req.valid, req.pred, req.dual_halfword_subtract, req.op, req.unit, req.opfield} = {2'b11, s2, op, u, opf};
        req.pred = pr;
        req.dst_reg = a[9:5];
        req.src2_reg = {2'b00, b[4], b[1:0]};
        req.src1 = a;
        req.src2 = b;
        amr_mode = r[15:0];
        amr_block0 = r[25:21];
        amr_block1 = r[20:16];
        if (pr && !ill)
            nexp++;
        @(posedge clk);
        #1;
        req = '0;
        if (!pr || ill)
            chk("refused", {46'h0, wb.we, illegal}, {46'h0, 1'b0, pr});
        else
            chk("wb", {wb.we, wb.pair, wb.dst_reg, wb.lo, wb.pair ? wb.hi : 8'h00, illegal},
                {1'b1, op == SFD_OP_ULONG && !s2, a[9:5], d[31:0], op == SFD_OP_ULONG && !s2 ? d[39:32] : 8'h00,
                 1'b0});
    endtask
    // --------------------------------
    // main sequence
    // --------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errors++;
            finish_test();
        end
    end
    initial
    begin
        logic [31:0] x;
        repeat (10) @(posedge clk);
        #1;
        reset = 0;
        go(SFD_OP_ABS4, SFD_UNIT_S, 7'h00, 1'b1, 1'b1, 32'h11056E30, 32'h11056980);
        go(SFD_OP_CSUB, SFD_UNIT_L, 7'h00, 1'b0, 1'b1, 32'h0000125A, 32'h00001F12);
        go(SFD_OP_CSUB, SFD_UNIT_L, 7'h00, 1'b0, 1'b1, 32'h00021A31, 32'h0001F63F);
        go(SFD_OP_ABS4, SFD_UNIT_L, 7'h00, 1'b0, 1'b1, 32'h3789F23A, 32'h04B84975);
        go(SFD_OP_ULONG, SFD_UNIT_L, 7'h2F, 1'b0, 1'b1, 32'h0000325A, 32'hFFFFFF12);
        go(SFD_OP_ADDR, SFD_UNIT_D, 7'h3B, 1'b0, 1'b1, 32'h00000002, 32'h00000100);
        $display("directed done");
        for (int n = 0; n < 600; n++)
        begin
            x = rnd();
            case (x[7:4] % 12)
                0, 1, 2, 3, 4, 5: go(SFD_OP_ADDR, SFD_UNIT_D, 7'h31 + 7'(2 * (x[7:4] % 12)), 1'b0, x[3:0] != 0, rnd(), rnd());
                6: go(SFD_OP_ABS4, SFD_UNIT_L, 7'h00, 1'b0, x[3:0] != 0, rnd(), rnd());
                7: go(SFD_OP_CSUB, SFD_UNIT_L, 7'h00, 1'b0, x[3:0] != 0, rnd() >> 1, rnd() >> 1);
                8, 9: go(SFD_OP_ULONG, SFD_UNIT_L, x[4] ? 7'h3F : 7'h2F, 1'b0, x[3:0] != 0, rnd(), rnd());
                10: go(SFD_OP_CSUB, sfd_unit_t'(3'h1 << (x[9:8] % 3)), 7'h00, 1'b1, x[3:0] != 0, rnd(), rnd());
                default: go(SFD_OP_ADDR, SFD_UNIT_L, 7'h31, 1'b0, x[3:0] != 0, rnd(), rnd());
            endcase
        end
        $display("random done");
        @(posedge clk);
        #1;
        chk("write count", {32'h0, writes}, 48'(nexp));
        finish_test();
    end
endmodule
